// File: hdl/ebv_defs.svh
// Constants for the external bus visibility controller.
// Assumes inclusion by bare name from the design files.
`ifndef EBV_DEFS_SVH
`define EBV_DEFS_SVH
`define EBV_AB_W 16
`define EBV_MODE_RESET 3'h4
`define EBV_STRAP_WAIT 2'h3
`define EBV_PIPE_ZERO 2'h0
`define EBV_WORD_ZERO 16'h0000
`endif

// File: hdl/ebv_pkg.sv
// Types for the external bus visibility controller.
// Assumes no other package; users write ebv_pkg::name.
package ebv_pkg;
  typedef enum logic [2:0] {
    EBV_SPECIAL_SINGLE = 3'h0,
    EBV_EMU_NARROW = 3'h1,
    EBV_SPECIAL_TEST = 3'h2,
    EBV_EMU_WIDE = 3'h3,
    EBV_NORMAL_SINGLE = 3'h4,
    EBV_NORMAL_NARROW = 3'h5,
    EBV_PERIPHERAL = 3'h6,
    EBV_NORMAL_WIDE = 3'h7
  } ebv_mode_type;
  typedef enum logic {
    EBV_PH_ADDR = 1'b0,
    EBV_PH_DATA = 1'b1
  } ebv_phase_type;
endpackage

// File: hdl/ebv_bus_visibility.sv
// External bus visibility controller: mode state, internal-cycle visibility on the
// multiplexed bus, secure and stop behaviour, and the tester port of peripheral mode.
// Assumes core-side access inputs are synchronous to core_clk and the tester
// drives its port synchronously to link_clk.
`timescale 1ns/1ps
`default_nettype none
`include "ebv_defs.svh"

// How it works
// (RQ1) Visibility only in wide expanded modes and emulation narrow mode.
// (RQ2) Visibility turns on only when software sets visibility_enable.
// (RQ3) Hidden internal cycle: clock low, read/write high, bus and strobe held.
// (RQ4) Visible debug-unit cycle: read/write high, data held, address and strobe updated.
// (RQ5) Visible no-access cycle, debug unit idle: read/write high, everything held.
// (RQ6) Secured chip ignores visibility_enable entirely.
// (RQ7) Secured chip drives pipe status outputs as zeros.
// (RQ8) Secured chip blocks writes to mode_select_bits.
// (RQ9) Special test mode lets protected bits be rewritten without reset.
// (RQ10) Peripheral mode halts the processor; tester drives ports A, B, E.
// (RQ11) Peripheral mode makes the mode register unwritable.
// (RQ12) Tester should avoid debug-unit activity in peripheral mode.
// (RQ13) Wide modes multiplex address and data on ports A and B.
// (RQ14) After a stop instruction the bus interface freezes until restarted.
// (RQ15) Single-chip modes keep address outputs from toggling.
// (RQ16) Pipe status outputs appear only when pipe_status_output_enable is set.
module ebv_bus_visibility (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic [2:0] mode_pins,
  input wire logic secure,
  input wire logic stop_exec,
  input wire logic stop_wake,
  input wire logic mode_wr,
  input wire logic [2:0] mode_wdata,
  input wire logic vis_wdata,
  input wire logic pe_assign_wr,
  input wire logic pipe_oe_wdata,
  input wire logic rdwe_wdata,
  input wire logic lstre_wdata,
  input wire logic acc_valid,
  input wire logic acc_internal,
  input wire logic [15:0] acc_addr,
  input wire logic [15:0] acc_data,
  input wire logic acc_rw,
  input wire logic acc_low_byte_strobe,
  input wire logic debug_sel,
  input wire logic no_access,
  input wire logic debug_drive,
  input wire logic [1:0] pipe_status_in,
  input wire logic [15:0] port_ab_in,
  input wire logic tester_strobe,
  input wire logic tester_rw,
  input wire logic tester_low_byte_strobe,
  output logic [15:0] port_ab_out,
  output logic port_ab_oe,
  output logic bus_phase_clock_out,
  output logic rw_out,
  output logic low_byte_strobe,
  output logic [1:0] instr_pipe_status,
  output logic instr_pipe_oe,
  output logic [2:0] mode_select_bits,
  output logic visibility_enable,
  output logic pipe_status_output_enable,
  output logic rdwe_out,
  output logic lstre_out,
  output logic stopped,
  output logic cpu_halt,
  output logic tester_req,
  output logic [15:0] tester_addr,
  output logic tester_write
);
  ebv_pkg::ebv_mode_type mode;
  ebv_pkg::ebv_phase_type phase;
  logic [2:0] strap_s1, strap_s2, strap_s3;
  logic [1:0] strap_cnt;
  logic strap_taken;
  logic mode_written, assign_written;
  logic [15:0] bus_addr, bus_data;
  logic cyc_show;
  // Link-domain state.
  logic per_s1, per_s2, per_s3, strobe_d, link_tog;
  logic [15:0] hold_ab;
  logic hold_rw, hold_low_byte_strobe;
  // Core-domain crossing of the link toggle.
  logic tog_s1, tog_s2, tog_s3, tog_seen;

  // Special test mode runs the bus expanded wide, like the emulation and normal wide modes.
  wire special_test = (mode == ebv_pkg::EBV_SPECIAL_TEST);
  wire expanded = mode[0] | special_test;
  wire wide = (mode[1] & mode[0]) | special_test;
  wire periph = (mode == ebv_pkg::EBV_PERIPHERAL);
  wire free_write = ~mode[2] & ~mode[0];
  wire vis_mode_ok = wide | (mode == ebv_pkg::EBV_EMU_NARROW); // see RQ1
  wire vis_on = vis_mode_ok & visibility_enable & ~secure; // see RQ2 see RQ6
  wire mode_wr_ok = mode_wr & strap_taken & ~periph & (free_write | ~mode_written); // see RQ9 see RQ11
  wire mod_wr_ok = mode_wr_ok & ~secure; // see RQ8
  wire assign_wr_ok = pe_assign_wr & strap_taken & ~periph & (free_write | ~assign_written);
  wire pipe_oe_eff = pipe_status_output_enable & expanded;
  wire take = (phase == ebv_pkg::EBV_PH_DATA) & ~stopped & expanded;
  wire hidden = acc_internal & ~vis_on;
  wire dbg_cyc = acc_internal & vis_on & debug_sel;
  wire idle_cyc = acc_internal & vis_on & ~debug_sel & no_access & ~debug_drive;
  wire upd_addr = acc_valid & ~hidden & ~idle_cyc;
  wire upd_data = acc_valid & ~hidden & ~idle_cyc & ~dbg_cyc;
  wire upd_rw = acc_valid & ~hidden & ~idle_cyc & ~dbg_cyc;
  wire [15:0] next_addr = upd_addr ? acc_addr : bus_addr;
  wire [15:0] next_data = upd_data ? acc_data : bus_data;
  wire next_rw = upd_rw ? acc_rw : 1'b1;
  wire next_low_byte_strobe = upd_addr ? acc_low_byte_strobe : low_byte_strobe;
  wire strap_ready = (strap_cnt == `EBV_STRAP_WAIT) & (strap_s2 == strap_s3);
  wire tog_event = (tog_s2 == tog_s3) & (tog_s3 != tog_seen);

  // Mode pins are caught after reset release once the synchroniser has settled.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_s1 <= 3'h0;
      strap_s2 <= 3'h0;
      strap_s3 <= 3'h0;
      strap_cnt <= 2'h0;
    end else begin
      strap_s1 <= mode_pins;
      strap_s2 <= strap_s1;
      strap_s3 <= strap_s2;
      if (strap_cnt != `EBV_STRAP_WAIT) begin
        strap_cnt <= strap_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode <= ebv_pkg::ebv_mode_type'(`EBV_MODE_RESET);
      strap_taken <= 1'b0;
      mode_written <= 1'b0;
      visibility_enable <= 1'b0;
    end else if (!strap_taken) begin
      if (strap_ready) begin
        mode <= ebv_pkg::ebv_mode_type'(strap_s3);
        strap_taken <= 1'b1;
      end
    end else if (mode_wr_ok) begin
      mode_written <= 1'b1;
      visibility_enable <= vis_wdata; // see RQ2
      if (mod_wr_ok) begin
        mode <= ebv_pkg::ebv_mode_type'(mode_wdata); // see RQ8
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      assign_written <= 1'b0;
      pipe_status_output_enable <= 1'b0;
      rdwe_out <= 1'b0;
      lstre_out <= 1'b0;
    end else if (assign_wr_ok) begin
      assign_written <= 1'b1;
      pipe_status_output_enable <= pipe_oe_wdata; // see RQ16
      rdwe_out <= rdwe_wdata;
      lstre_out <= lstre_wdata;
    end
  end

  // Stop freezes the bus until the wake input restarts it.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stopped <= 1'b0;
    end else if (stop_wake) begin
      stopped <= 1'b0;
    end else if (stop_exec) begin
      stopped <= 1'b1; // see RQ14
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= ebv_pkg::EBV_PH_ADDR;
    end else if (!stopped) begin
      phase <= (phase == ebv_pkg::EBV_PH_ADDR) ? ebv_pkg::EBV_PH_DATA : ebv_pkg::EBV_PH_ADDR;
    end
  end

  // Registers are only loaded in expanded modes, so single-chip address lines stay quiet.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_addr <= `EBV_WORD_ZERO;
      bus_data <= `EBV_WORD_ZERO;
      rw_out <= 1'b1;
      low_byte_strobe <= 1'b1;
      cyc_show <= 1'b0;
    end else if (take) begin
      bus_addr <= next_addr; // see RQ3 see RQ4 see RQ5 see RQ15
      bus_data <= next_data;
      rw_out <= next_rw;
      low_byte_strobe <= next_low_byte_strobe;
      cyc_show <= acc_valid & ~hidden;
    end
  end

  // Address phase then data phase on the shared A/B lines.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_ab_out <= `EBV_WORD_ZERO;
      port_ab_oe <= 1'b0;
      bus_phase_clock_out <= 1'b0;
    end else begin
      port_ab_oe <= expanded & ~periph & ~stopped; // see RQ13
      if (stopped || !expanded) begin
        bus_phase_clock_out <= 1'b0;
      end else if (phase == ebv_pkg::EBV_PH_DATA) begin
        port_ab_out <= next_addr;
        bus_phase_clock_out <= 1'b0;
      end else begin
        port_ab_out <= bus_data; // see RQ13
        bus_phase_clock_out <= cyc_show; // see RQ3
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      instr_pipe_status <= `EBV_PIPE_ZERO;
      instr_pipe_oe <= 1'b0;
      cpu_halt <= 1'b0;
    end else begin
      instr_pipe_oe <= pipe_oe_eff; // see RQ16
      instr_pipe_status <= (pipe_oe_eff & ~secure) ? pipe_status_in : `EBV_PIPE_ZERO; // see RQ7
      cpu_halt <= periph & strap_taken; // see RQ10
    end
  end

  // Tester port: captured on the link clock, announced by a toggle.
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      per_s1 <= 1'b0;
      per_s2 <= 1'b0;
      per_s3 <= 1'b0;
      strobe_d <= 1'b0;
      link_tog <= 1'b0;
      hold_ab <= `EBV_WORD_ZERO;
      hold_rw <= 1'b1;
      hold_low_byte_strobe <= 1'b1;
    end else begin
      per_s1 <= cpu_halt;
      per_s2 <= per_s1;
      per_s3 <= per_s2;
      strobe_d <= tester_strobe;
      if (per_s2 && per_s3 && tester_strobe && !strobe_d) begin
        hold_ab <= port_ab_in; // see RQ10
        hold_rw <= tester_rw;
        hold_low_byte_strobe <= tester_low_byte_strobe;
        link_tog <= ~link_tog;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
      tog_seen <= 1'b0;
      tester_req <= 1'b0;
      tester_addr <= `EBV_WORD_ZERO;
      tester_write <= 1'b0;
    end else begin
      tog_s1 <= link_tog;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
      tester_req <= tog_event & periph;
      if (tog_event) begin
        tog_seen <= tog_s3;
        tester_addr <= hold_ab;
        tester_write <= ~hold_rw;
      end
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  vis_mode_gate_a: assert property ((take && acc_valid && acc_internal && // see RQ1
    mode != ebv_pkg::EBV_EMU_NARROW && mode != ebv_pkg::EBV_SPECIAL_TEST &&
    mode != ebv_pkg::EBV_EMU_WIDE && mode != ebv_pkg::EBV_NORMAL_WIDE)
    |=> ##1 !bus_phase_clock_out)
    else $error("Visibility active in a mode that forbids it.");
  hidden_cycle_a: assert property ((take && acc_valid && acc_internal && !vis_on) // see RQ3
    |=> rw_out && $stable(bus_addr) && $stable(bus_data) ##1 !bus_phase_clock_out)
    else $error("Hidden internal cycle leaked onto the bus.");
  debug_cycle_a: assert property ((take && acc_valid && acc_internal && vis_on && debug_sel) // see RQ4
    |=> rw_out && bus_addr == $past(acc_addr) && $stable(bus_data))
    else $error("Debug-unit cycle shown wrongly.");
  idle_cycle_a: assert property ((take && acc_valid && idle_cyc) // see RQ5
    |=> rw_out && $stable(bus_addr) && $stable(bus_data) && $stable(low_byte_strobe))
    else $error("No-access cycle changed the bus.");
  secure_novis_a: assert property ((take && acc_valid && acc_internal && secure) // see RQ6
    |=> ##1 !bus_phase_clock_out)
    else $error("Internal cycle visible while secured.");
  pipe_secure_a: assert property (secure |=> instr_pipe_status == `EBV_PIPE_ZERO) // see RQ7
    else $error("Pipe status exposed while secured.");
  mode_lock_a: assert property ((secure && strap_taken) |=> $stable(mode_select_bits)) // see RQ8
    else $error("Mode select bits changed while secured.");
  test_rewrite_a: assert property ((strap_taken && mode == ebv_pkg::EBV_SPECIAL_TEST // see RQ9
    && mode_wr && !secure) |=> mode_select_bits == $past(mode_wdata))
    else $error("Special test mode write refused.");
  cpu_halt_a: assert property ((periph && strap_taken) |=> cpu_halt) // see RQ10
    else $error("Processor not halted in peripheral mode.");
  periph_lock_a: assert property ((periph && strap_taken) // see RQ11
    |=> $stable(mode_select_bits) && $stable(visibility_enable))
    else $error("Mode register written in peripheral mode.");
  stop_freeze_a: assert property ((stopped && !stop_wake) |=> !bus_phase_clock_out // see RQ14
    && $stable(port_ab_out) && $stable(bus_addr))
    else $error("Bus moved while stopped.");
  single_quiet_a: assert property ((!expanded && strap_taken) |=> $stable(bus_addr)) // see RQ15
    else $error("Address toggled in single-chip mode.");
  pipe_enable_a: assert property (!pipe_oe_eff |=> !instr_pipe_oe // see RQ16
    && instr_pipe_status == `EBV_PIPE_ZERO)
    else $error("Pipe status shown without its enable.");

  assign mode_select_bits = mode;
endmodule
`default_nettype wire

// File: tb/ebv_tester_model.sv
// Tester model for peripheral mode: link clock, address port and request strobe.
// Assumes the bench calls send() only while the design sits in peripheral mode.
`timescale 1ns/1ps
`default_nettype none
module ebv_tester_model (
  input wire logic rst_b,
  output logic link_clk,
  output logic [15:0] port_ab_in,
  output logic tester_strobe,
  output logic tester_rw,
  output logic tester_low_byte_strobe
);
  logic run;
  // The link clock runs during reset and within a request frame only.
  initial begin
    link_clk = 1'h0;
    run = 1'h0;
    port_ab_in = 16'h5a5a;
    tester_strobe = 1'h0;
    tester_rw = 1'h1;
    tester_low_byte_strobe = 1'h1;
    #3.7;
    forever begin
      #6;
      link_clk = (!rst_b || run) ? ~link_clk : 1'h0;
    end
  end
  // The tester drives address, direction and strobe itself.
  task automatic send(input logic [15:0] addr, input logic rd);
    run = 1'h1;
    repeat (4) @(posedge link_clk);
    #1;
    port_ab_in = addr;
    tester_rw = rd;
    tester_low_byte_strobe = 1'h0;
    tester_strobe = 1'h1;
    repeat (3) @(posedge link_clk);
    #1;
    tester_strobe = 1'h0;
    tester_low_byte_strobe = 1'h1;
    // Released lines must not keep showing the old address.
    port_ab_in = ~addr;
    repeat (2) @(posedge link_clk);
    run = 1'h0;
  endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Bench for the bus visibility controller: modes, visibility, secure, stop, tester.
// Assumes the tester model supplies the link clock and the tester port.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk, rst_b, link_clk, secure, stop_exec, stop_wake, mode_wr, vis_wdata;
  logic pe_assign_wr, pipe_oe_wdata, rdwe_wdata, lstre_wdata, acc_valid, acc_internal;
  logic acc_rw, acc_low_byte_strobe, debug_sel, no_access, debug_drive, tester_strobe, tester_rw;
  logic tester_low_byte_strobe, port_ab_oe, bus_phase_clock_out, rw_out, low_byte_strobe;
  logic instr_pipe_oe, visibility_enable, pipe_status_output_enable, rdwe_out, lstre_out;
  logic stopped, cpu_halt, tester_req, tester_write, a_rw, a_ls, d_clk;
  logic [2:0] mode_pins, mode_wdata, mode_select_bits;
  logic [1:0] pipe_status_in, instr_pipe_status;
  logic [15:0] acc_addr, acc_data, port_ab_in, port_ab_out, tester_addr, a_ab, d_ab;
  int n_errors = 0;
  int compares = 0;
  int ecount;
  int k;
  ebv_bus_visibility dut (.core_clk, .rst_b, .link_clk, .mode_pins, .secure, .stop_exec,
    .stop_wake, .mode_wr, .mode_wdata, .vis_wdata, .pe_assign_wr, .pipe_oe_wdata,
    .rdwe_wdata, .lstre_wdata, .acc_valid, .acc_internal, .acc_addr, .acc_data, .acc_rw,
    .acc_low_byte_strobe, .debug_sel, .no_access, .debug_drive, .pipe_status_in, .port_ab_in,
    .tester_strobe, .tester_rw, .tester_low_byte_strobe, .port_ab_out, .port_ab_oe,
    .bus_phase_clock_out, .rw_out, .low_byte_strobe, .instr_pipe_status, .instr_pipe_oe,
    .mode_select_bits, .visibility_enable, .pipe_status_output_enable, .rdwe_out,
    .lstre_out, .stopped, .cpu_halt, .tester_req, .tester_addr, .tester_write);
  ebv_tester_model tester (.rst_b, .link_clk, .port_ab_in, .tester_strobe, .tester_rw,
    .tester_low_byte_strobe);
  initial begin
    core_clk = 1'h0;
    forever #50 core_clk = ~core_clk;
  end
  // Counts core edges since reset; odd edges carry the data phase.
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) ecount <= 0;
    else ecount <= ecount + 1;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict;
    if (n_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic restart(input logic [2:0] m, input logic sec);
    rst_b = 1'h0;
    mode_pins = m;
    secure = sec;
    repeat (5) @(negedge core_clk);
    chk("rw_out in reset", 16'h0001, rw_out);
    chk("strobe in reset", 16'h0001, low_byte_strobe);
    rst_b = 1'h1;
    repeat (6) @(negedge core_clk);
  endtask
  task automatic wr_mode(input logic [2:0] m, input logic v);
    mode_wr = 1'h1;
    mode_wdata = m;
    vis_wdata = v;
    @(negedge core_clk);
    mode_wr = 1'h0;
    @(negedge core_clk);
  endtask
  task automatic wr_pe(input logic p, input logic r, input logic l);
    pe_assign_wr = 1'h1;
    pipe_oe_wdata = p;
    rdwe_wdata = r;
    lstre_wdata = l;
    @(negedge core_clk);
    pe_assign_wr = 1'h0;
    @(negedge core_clk);
  endtask
  task automatic cyc(input logic intl, dsel, noacc, input logic [15:0] a, d, input logic rw);
    while (ecount[0] !== 1'h1) @(negedge core_clk);
    acc_valid = 1'h1;
    acc_internal = intl;
    debug_sel = dsel;
    no_access = noacc;
    acc_addr = a;
    acc_data = d;
    acc_rw = rw;
    acc_low_byte_strobe = ~a[0];
    @(negedge core_clk);
    acc_valid = 1'h0;
    debug_sel = 1'h0;
    no_access = 1'h0;
    a_ab = port_ab_out;
    a_rw = rw_out;
    a_ls = low_byte_strobe;
    @(negedge core_clk);
    d_ab = port_ab_out;
    d_clk = bus_phase_clock_out;
  endtask
  initial begin
    #100000;
    n_errors++;
    give_verdict;
  end
  initial begin
    {stop_exec, stop_wake, mode_wr, vis_wdata, pe_assign_wr, pipe_oe_wdata} = 6'h00;
    {rdwe_wdata, lstre_wdata, acc_valid, acc_internal, debug_sel, no_access} = 6'h00;
    {acc_rw, acc_low_byte_strobe, debug_drive, mode_wdata, acc_addr, acc_data} = 38'h0;
    rst_b = 1'h0;
    secure = 1'h0;
    mode_pins = 3'h2;
    pipe_status_in = 2'h2;
    restart(3'h2, 1'h0);
    wr_mode(3'h2, 1'h1);
    cyc(1'h1, 1'h0, 1'h0, 16'h0606, 16'h0707, 1'h1);
    chk("test clk", 16'h0001, d_clk);
    chk("test addr", 16'h0606, a_ab);
    wr_mode(3'h2, 1'h0);
    chk("vis rewritten", 16'h0000, visibility_enable);
    wr_pe(1'h1, 1'h1, 1'h0);
    chk("rdwe", 16'h0001, rdwe_out);
    wr_mode(3'h3, 1'h1);
    wr_mode(3'h7, 1'h0);
    chk("mode once", 16'h0003, mode_select_bits);
    chk("vis set", 16'h0001, visibility_enable);
    chk("pipe shown", 16'h0002, instr_pipe_status);
    chk("pipe oe", 16'h0001, instr_pipe_oe);
    chk("pipe enable", 16'h0001, pipe_status_output_enable);
    cyc(1'h0, 1'h0, 1'h0, 16'h1234, 16'hbeef, 1'h0);
    chk("ext addr", 16'h1234, a_ab);
    chk("ext rw", 16'h0000, a_rw);
    chk("ext data", 16'hbeef, d_ab);
    chk("ext clk", 16'h0001, d_clk);
    chk("ext oe", 16'h0001, port_ab_oe);
    cyc(1'h1, 1'h1, 1'h0, 16'h5671, 16'h0f0f, 1'h0);
    chk("dbg addr", 16'h5671, a_ab);
    chk("dbg rw", 16'h0001, a_rw);
    chk("dbg strobe", 16'h0000, a_ls);
    chk("dbg data", 16'hbeef, d_ab);
    cyc(1'h1, 1'h0, 1'h1, 16'h2222, 16'h3333, 1'h0);
    chk("noacc addr", 16'h5671, a_ab);
    chk("noacc rw", 16'h0001, a_rw);
    chk("noacc strobe", 16'h0000, a_ls);
    chk("noacc data", 16'hbeef, d_ab);
    cyc(1'h1, 1'h0, 1'h0, 16'h4444, 16'h5555, 1'h1);
    chk("int shown", 16'h0001, d_clk);
    stop_exec = 1'h1;
    @(negedge core_clk);
    stop_exec = 1'h0;
    chk("stopped", 16'h0001, stopped);
    cyc(1'h0, 1'h0, 1'h0, 16'h9999, 16'h8888, 1'h0);
    chk("stop addr", 16'h4444, a_ab);
    chk("stop clk", 16'h0000, d_clk);
    stop_wake = 1'h1;
    @(negedge core_clk);
    stop_wake = 1'h0;
    chk("woken", 16'h0000, stopped);
    restart(3'h3, 1'h0);
    cyc(1'h0, 1'h0, 1'h0, 16'h1111, 16'haaaa, 1'h0);
    cyc(1'h1, 1'h0, 1'h0, 16'h7776, 16'h6666, 1'h0);
    chk("hidden addr", 16'h1111, a_ab);
    chk("hidden rw", 16'h0001, a_rw);
    chk("hidden strobe", 16'h0000, a_ls);
    chk("hidden data", 16'haaaa, d_ab);
    chk("hidden clk", 16'h0000, d_clk);
    restart(3'h3, 1'h1);
    wr_mode(3'h7, 1'h1);
    chk("secure mode", 16'h0003, mode_select_bits);
    wr_pe(1'h1, 1'h0, 1'h1);
    chk("secure pipe", 16'h0000, instr_pipe_status);
    chk("lstre", 16'h0001, lstre_out);
    cyc(1'h1, 1'h0, 1'h0, 16'h0101, 16'h0202, 1'h1);
    chk("secure clk", 16'h0000, d_clk);
    restart(3'h5, 1'h0);
    wr_mode(3'h5, 1'h1);
    cyc(1'h1, 1'h0, 1'h0, 16'h0303, 16'h0404, 1'h1);
    chk("narrow clk", 16'h0000, d_clk);
    restart(3'h4, 1'h0);
    cyc(1'h0, 1'h0, 1'h0, 16'hffff, 16'hffff, 1'h0);
    chk("single addr", 16'h0000, a_ab);
    chk("single oe", 16'h0000, port_ab_oe);
    restart(3'h6, 1'h0);
    chk("halt", 16'h0001, cpu_halt);
    wr_mode(3'h7, 1'h1);
    chk("periph mode", 16'h0006, mode_select_bits);
    // The debug unit stays idle while the tester owns the bus.
    fork
      tester.send(16'hc3a5, 1'h0);
      begin
        for (k = 0; k < 40 && tester_req !== 1'h1; k++) @(negedge core_clk);
        chk("tester req", 16'h0001, tester_req);
        chk("tester addr", 16'hc3a5, tester_addr);
        chk("tester write", 16'h0001, tester_write);
      end
    join
    give_verdict;
  end
endmodule
`default_nettype wire
